// File: hdl/gptw_pkg.sv
// Constants, register map and walk states of the graphics page walker.
// Assumes one core clock; all entries are 64-bit little-endian quadwords.
package gptw_pkg;
  localparam int          PA_W        = 46;
  localparam int          HAW_CLIENT  = 39;
  localparam int          HAW_SERVER  = 46;
  localparam logic [33:0] GTT_BYTES   = 34'h0_0080_0000;
  localparam logic [33:0] VA_SPAN     = 34'h1_0000_0000;
  localparam logic [20:0] GTT_ENTRIES = 21'h10_0000;
  localparam int          ENT_BYTES   = 8;
  localparam int          ENT_W       = 64;
  localparam int          QW_SH       = 3;
  localparam int          PG4K_SH     = 12;
  localparam int          PG64K_SH    = 16;
  localparam int          B_PRESENT   = 0;
  localparam int          B_RW        = 1;
  localparam int          B_PWT       = 3;
  localparam int          B_PCD       = 4;
  localparam int          B_PAT       = 7;
  localparam int          B_NULL      = 9;
  localparam int          B_BIG       = 11;
  localparam int          DIR_SH      = 21;
  localparam int          DIR_N       = 2048;
  localparam logic [7:0]  OFF_CTRL    = 8'h00;
  localparam logic [7:0]  OFF_GBASE_L = 8'h04;
  localparam logic [7:0]  OFF_GBASE_H = 8'h08;
  localparam logic [7:0]  OFF_PDP_L   = 8'h0C;
  localparam logic [7:0]  OFF_PDP_H   = 8'h10;
  localparam logic [7:0]  OFF_STATUS  = 8'h14;
  localparam int          C_SERVER    = 0;
  localparam int          C_NESTED    = 1;
  localparam int          C_INVAL     = 2;
  localparam logic [2:0]  CTRL_RST    = 3'h0;
  typedef enum logic [2:0] {
    GPTW_IDLE = 3'b000,
    GPTW_DIR  = 3'b001,
    GPTW_PTE  = 3'b010,
    GPTW_GTT  = 3'b011,
    GPTW_UPD  = 3'b100
  } gptw_state_t;
endpackage : gptw_pkg

// File: hdl/gptw_walker.sv
// Page walker: global table and legacy 32-bit two-level walk, APB registers.
// Assumes memory answers each mem_req with one mem_done pulse and a 128-bit line.
`timescale 1ns/100ps
module gptw_walker import gptw_pkg::*; #(
  parameter int MEM_DW = 128
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              req_valid,
  input  wire logic              req_global,
  input  wire logic              req_write,
  input  wire logic [31:0]       req_addr,
  output logic                   req_ready,
  input  wire logic              upd_valid,
  input  wire logic [31:0]       upd_page,
  input  wire logic [ENT_W-1:0]  upd_entry,
  output logic                   resp_valid,
  output logic      [PA_W-1:0]   resp_pa,
  output logic                   resp_fault,
  output logic                   resp_null,
  output logic                   resp_wr_deny,
  output logic      [2:0]        resp_mem_type,
  output logic                   resp_guest,
  output logic                   mem_req,
  output logic                   mem_we,
  output logic                   mem_uc,
  output logic      [PA_W-1:0]   mem_addr,
  output logic      [ENT_W-1:0]  mem_wdata,
  input  wire logic              mem_done,
  input  wire logic [MEM_DW-1:0] mem_rdata
);
  gptw_state_t state;
  gptw_state_t next_state;
  logic [2:0]      ctrl;
  logic [PA_W-1:0] gbase;
  logic [PA_W-1:0] directory_pointer_base;
  logic [31:0]     va;
  logic            wr_q;
  logic [PA_W-1:0] next_mem_addr;
  // Directory cache: 2048 entries cover the four 4KB directory pages
  logic [PA_W-13:0] dir_pt  [DIR_N];
  logic [DIR_N-1:0] dir_big;
  logic [DIR_N-1:0] dir_vld;

  // APB decode
  wire        apb_acc  = psel && penable && pready;
  wire        apb_wr   = apb_acc && pwrite;
  wire        hit_ctrl = paddr == OFF_CTRL;
  wire        hit_gl   = paddr == OFF_GBASE_L;
  wire        hit_gh   = paddr == OFF_GBASE_H;
  wire        hit_pl   = paddr == OFF_PDP_L;
  wire        hit_ph   = paddr == OFF_PDP_H;
  wire        hit_st   = paddr == OFF_STATUS;
  wire        mapped   = hit_ctrl | hit_gl | hit_gh | hit_pl | hit_ph | hit_st;
  wire        inval    = apb_wr && hit_ctrl && pwdata[C_INVAL];
  wire [31:0] rd_mux   = hit_ctrl ? {29'h0, ctrl} :
                         hit_gl   ? gbase[31:0] :
                         hit_gh   ? {18'h0, gbase[PA_W-1:32]} :
                         hit_pl   ? directory_pointer_base[31:0] :
                         hit_ph   ? {18'h0, directory_pointer_base[PA_W-1:32]} :
                         hit_st   ? {31'h0, state != GPTW_IDLE} : 32'h0;

  // Entry field extraction
  wire [PA_W-1:0] haw_mask = {{(PA_W-HAW_CLIENT){ctrl[C_SERVER]}}, {HAW_CLIENT{1'b1}}};
  wire [ENT_W-1:0] slot   = mem_rdata[mem_addr[QW_SH]*ENT_W +: ENT_W];
  wire [PA_W-1:0]  ent_pa = slot[PA_W-1:0] & haw_mask;
  wire [PA_W-13:0] ent_pg = ent_pa[PA_W-1:PG4K_SH];
  wire             ent_p  = slot[B_PRESENT];

  // Request addresses
  wire [10:0]      dir_idx = va[31:DIR_SH];
  wire             req_big = dir_big[req_addr[31:DIR_SH]];
  wire             dir_hit = dir_vld[req_addr[31:DIR_SH]];
  wire [PA_W-1:0]  pde_a   = directory_pointer_base + {{(PA_W-14){1'b0}}, req_addr[31:DIR_SH], 3'h0};
  wire [PA_W-1:0]  gtt_a   = gbase + {{(PA_W-23){1'b0}}, req_addr[31:PG4K_SH], 3'h0};
  wire [PA_W-1:0]  upd_a   = gbase + {{(PA_W-23){1'b0}}, upd_page[31:PG4K_SH], 3'h0};
  // Large pages read every sixteenth page entry only
  wire [8:0] idx_hit = req_big ? {req_addr[20:PG64K_SH], 4'h0} : req_addr[20:12];
  wire [8:0] idx_new = slot[B_BIG] ? {va[20:PG64K_SH], 4'h0} : va[20:12];
  wire [PA_W-1:0] pte_hit = {dir_pt[req_addr[31:DIR_SH]], 12'h0} +
                            {{(PA_W-12){1'b0}}, idx_hit, 3'h0};
  wire [PA_W-1:0] pte_new = {ent_pg, 12'h0} + {{(PA_W-12){1'b0}}, idx_new, 3'h0};

  wire take_upd = state == GPTW_IDLE && upd_valid;
  wire take_req = state == GPTW_IDLE && !upd_valid && req_valid;
  wire done_dir = state == GPTW_DIR && mem_done;
  wire done_pte = state == GPTW_PTE && mem_done;
  wire done_gtt = state == GPTW_GTT && mem_done;
  // Directory entry bit 1 never enters the cache: it has no effect here
  wire dir_ok   = done_dir && ent_p;

  always_comb begin
    next_state    = state;
    next_mem_addr = mem_addr;
    case (state)
      GPTW_IDLE: begin
        if (upd_valid) begin
          next_state    = GPTW_UPD;
          next_mem_addr = upd_a;
        end else if (req_valid && req_global) begin
          next_state    = GPTW_GTT;
          next_mem_addr = gtt_a;
        end else if (req_valid && dir_hit) begin
          next_state    = GPTW_PTE;
          next_mem_addr = pte_hit;
        end else if (req_valid) begin
          next_state    = GPTW_DIR;
          next_mem_addr = pde_a;
        end
      end
      GPTW_DIR: begin
        if (mem_done) begin
          next_state    = ent_p ? GPTW_PTE : GPTW_IDLE;
          next_mem_addr = pte_new;
        end
      end
      GPTW_PTE, GPTW_GTT, GPTW_UPD: begin
        if (mem_done) begin
          next_state = GPTW_IDLE;
        end
      end
      default: next_state = GPTW_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= GPTW_IDLE;
      mem_addr <= '0;
    end else begin
      state <= next_state;
      mem_addr <= next_mem_addr;
    end
  end

  // APB slave: one access cycle, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel && !penable && !pready;
      pslverr <= psel && !penable && !pready && !mapped;
      prdata  <= (psel && !penable) ? rd_mux : prdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl  <= CTRL_RST;
      gbase <= '0;
      directory_pointer_base   <= '0;
    end else if (apb_wr) begin
      if (hit_ctrl) ctrl <= {1'b0, pwdata[C_NESTED:C_SERVER]};
      if (hit_gl) gbase[31:0] <= pwdata;
      if (hit_gh) gbase[PA_W-1:32] <= pwdata[PA_W-33:0];
      if (hit_pl) directory_pointer_base[31:0] <= pwdata;
      if (hit_ph) directory_pointer_base[PA_W-1:32] <= pwdata[PA_W-33:0];
    end
  end

  // Cache fill wins over an invalidate in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_vld <= '0;
      dir_big <= '0;
    end else begin
      if (inval) dir_vld <= '0;
      if (dir_ok) begin
        dir_vld[dir_idx] <= 1'b1;
        dir_big[dir_idx] <= slot[B_BIG];
      end
    end
  end

  always_ff @(posedge pclk) begin
    if (dir_ok) dir_pt[dir_idx] <= ent_pg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      va        <= 32'h0;
      wr_q      <= 1'b0;
      req_ready <= 1'b0;
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_uc    <= 1'b0;
      mem_wdata <= '0;
    end else begin
      req_ready <= next_state == GPTW_IDLE && !take_req && !take_upd;
      mem_req   <= next_state != GPTW_IDLE;
      mem_we    <= next_state == GPTW_UPD;
      mem_uc    <= next_state == GPTW_GTT || next_state == GPTW_UPD;
      if (take_req) begin
        va   <= req_addr;
        wr_q <= req_write;
      end
      if (take_upd) mem_wdata <= upd_entry;
    end
  end

  // Legacy page result: 64KB pages keep VA bits 15:0 below the page base
  wire            big_q  = dir_big[dir_idx];
  wire [PA_W-1:0] pg_pa  = big_q ? {ent_pa[PA_W-1:PG64K_SH], va[15:0]}
                                 : {ent_pg, va[11:0]};
  wire            is_nul = ent_p && slot[B_NULL];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp_valid    <= 1'b0;
      resp_pa       <= '0;
      resp_fault    <= 1'b0;
      resp_null     <= 1'b0;
      resp_wr_deny  <= 1'b0;
      resp_mem_type <= 3'h0;
      resp_guest    <= 1'b0;
    end else begin
      resp_valid    <= done_pte || done_gtt || (done_dir && !ent_p);
      resp_fault    <= (done_pte || done_gtt || done_dir) && !ent_p;
      resp_null     <= done_pte && is_nul;
      resp_wr_deny  <= done_pte && ent_p && wr_q && !slot[B_RW];
      resp_mem_type <= done_pte ? {slot[B_PAT], slot[B_PCD], slot[B_PWT]} : 3'h0;
      resp_guest    <= (done_pte || done_dir) && ctrl[C_NESTED];
      if (done_gtt) resp_pa <= ent_p ? {ent_pg, va[11:0]} : '0;
      else if (done_pte) resp_pa <= (ent_p && !is_nul) ? pg_pa : '0;
      else if (done_dir) resp_pa <= '0;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_pte_done;
    state == GPTW_PTE && mem_done;
  endsequence
  sequence s_take_legacy;
    take_req && !req_global;
  endsequence
  sequence s_gtt_done;
    state == GPTW_GTT && mem_done;
  endsequence
  sequence s_dir_done;
    state == GPTW_DIR && mem_done;
  endsequence
  sequence s_upd_done;
    state == GPTW_UPD && mem_done;
  endsequence

  global_walk_a: assert property (take_req && req_global |=> state == GPTW_GTT && mem_uc)
    else $error("global request did not walk the global table");
  gtt_uncached_a: assert property (mem_req && state == GPTW_GTT |-> mem_uc)
    else $error("global table read not uncacheable");
  upd_slot_a: assert property (take_upd |=> mem_we && mem_addr ==
    gbase + {{(PA_W-23){1'b0}}, $past(upd_page[31:12]), 3'h0})
    else $error("update quadword position wrong");
  dir_hit_a: assert property (s_take_legacy ##0 dir_hit |=> state == GPTW_PTE)
    else $error("cached directory entry fetched again");
  big_index_a: assert property (state == GPTW_PTE && big_q |-> mem_addr[6:3] == 4'h0)
    else $error("64KB page entry index not sixteen aligned");
  fault_a: assert property ((s_pte_done or (state == GPTW_GTT && mem_done)) ##0 !ent_p
    |=> resp_valid && resp_fault && resp_pa == '0)
    else $error("absent entry not faulted");
  null_a: assert property (s_pte_done ##0 is_nul |=> resp_null && resp_pa == '0)
    else $error("null page not zeroed");
  deny_a: assert property (s_pte_done ##0 (ent_p && wr_q && !slot[B_RW]) |=> resp_wr_deny)
    else $error("write to read-only page not refused");
  mem_type_a: assert property (s_pte_done |=>
    resp_mem_type == $past({slot[B_PAT], slot[B_PCD], slot[B_PWT]}))
    else $error("memory type bits wrong");
  haw_client_a: assert property (resp_valid && !ctrl[C_SERVER] |-> resp_pa[PA_W-1:HAW_CLIENT] == '0)
    else $error("address above client width");
  legacy_two_a: assert property (s_take_legacy ##0 !dir_hit |=> state == GPTW_DIR
    ##[0:300] done_dir)
    else $error("legacy walk skipped directory level");

  gtt_addr_a: assert property (take_req && req_global
    |=> mem_addr == $past(gbase) + {{(PA_W-23){1'b0}}, $past(req_addr[31:PG4K_SH]), 3'h0})
    else $error("global entry address wrong");
  pde_addr_a: assert property (s_take_legacy ##0 !dir_hit
    |=> mem_addr == $past(directory_pointer_base) + {{(PA_W-14){1'b0}}, $past(req_addr[31:DIR_SH]), 3'h0})
    else $error("directory entry address wrong");
  pte_align_a: assert property (s_dir_done ##0 (ent_p && !slot[B_BIG])
    |=> mem_addr[PG4K_SH-1:0] == {$past(va[20:12]), 3'h0})
    else $error("page entry offset wrong");

  gtt_pa_a: assert property (s_gtt_done ##0 ent_p
    |=> resp_pa[HAW_CLIENT-1:PG4K_SH] == $past(slot[HAW_CLIENT-1:PG4K_SH]))
    else $error("global page address wrong");
  haw_server_a: assert property (s_gtt_done ##0 (ent_p && ctrl[C_SERVER])
    |=> resp_pa[PA_W-1:HAW_CLIENT] == $past(slot[PA_W-1:HAW_CLIENT]))
    else $error("server width bits lost");
  small_pa_a: assert property (s_pte_done ##0 (ent_p && !is_nul && !big_q)
    |=> resp_pa[PG4K_SH-1:0] == $past(va[11:0]))
    else $error("4KB page offset wrong");
  big_pa_a: assert property (s_pte_done ##0 (ent_p && !is_nul && big_q)
    |=> resp_pa[PG64K_SH-1:0] == $past(va[15:0]))
    else $error("64KB page offset wrong");
  guest_a: assert property (s_pte_done
    |=> resp_guest == $past(ctrl[C_NESTED]))
    else $error("guest marking wrong");
  gtt_type_a: assert property (s_gtt_done
    |=> resp_mem_type == 3'h0 && !resp_guest && !resp_null && !resp_wr_deny)
    else $error("global result carries legacy fields");
  null_drop_a: assert property (s_pte_done ##0 is_nul
    |=> resp_valid && !resp_fault)
    else $error("null page not completed");
  deny_read_a: assert property (s_pte_done ##0 !wr_q
    |=> !resp_wr_deny)
    else $error("read refused");

  dir_absent_a: assert property (s_dir_done ##0 !ent_p
    |=> state == GPTW_IDLE && resp_valid && resp_fault)
    else $error("absent directory entry not faulted");
  dir_present_a: assert property (s_dir_done ##0 ent_p
    |=> state == GPTW_PTE && !resp_valid)
    else $error("second level skipped");
  upd_no_resp_a: assert property (s_upd_done
    |=> state == GPTW_IDLE && !resp_valid)
    else $error("update produced a response");
  resp_one_a: assert property (resp_valid
    |=> !resp_valid)
    else $error("response longer than one cycle");
  busy_ready_a: assert property (state != GPTW_IDLE
    |-> !req_ready)
    else $error("ready while busy");
  mem_busy_a: assert property (state != GPTW_IDLE
    |-> mem_req)
    else $error("memory request dropped");
  mem_idle_a: assert property (state == GPTW_IDLE
    |-> !mem_req)
    else $error("memory request while idle");
  upd_write_a: assert property (state == GPTW_UPD
    |-> mem_we && mem_uc)
    else $error("update write not uncacheable");
  write_only_a: assert property (mem_we
    |-> state == GPTW_UPD)
    else $error("memory write outside update");
  upd_data_a: assert property (take_upd
    |=> mem_wdata == $past(upd_entry))
    else $error("update data wrong");

  apb_ready_a: assert property (psel && !penable && !pready
    |=> pready)
    else $error("access phase not ready");
  apb_one_a: assert property (pready
    |=> !pready)
    else $error("ready longer than one cycle");
  apb_err_a: assert property (psel && !penable && !pready && !mapped
    |=> pslverr)
    else $error("unmapped access not flagged");
  apb_rdata_a: assert property (psel && !penable
    |=> prdata == $past(rd_mux))
    else $error("read data not latched");
  unmapped_zero_a: assert property (psel && !penable && !mapped
    |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  ctrl_write_a: assert property (apb_wr && hit_ctrl
    |=> ctrl == {1'b0, $past(pwdata[C_NESTED:C_SERVER])})
    else $error("control write wrong");
  gbase_write_a: assert property (apb_wr && hit_gl
    |=> gbase[31:0] == $past(pwdata))
    else $error("global base write wrong");
  pdp_write_a: assert property (apb_wr && hit_pl
    |=> directory_pointer_base[31:0] == $past(pwdata))
    else $error("directory base write wrong");
  inval_clear_a: assert property (inval && !dir_ok
    |=> dir_vld == '0)
    else $error("directory cache not cleared");
  fill_set_a: assert property (dir_ok
    |=> dir_vld[$past(dir_idx)])
    else $error("directory fill lost");
endmodule : gptw_walker

// File: test/gptw_mem_model.sv
// Memory model holding translation tables as 8B entries inside 128-bit lines.
// Assumes the walker holds mem_req and mem_addr until mem_done, one done per request.
`timescale 1ns/100ps
module gptw_mem_model import gptw_pkg::*; (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [3:0]       lat,
  input  wire logic             mem_req,
  input  wire logic             mem_we,
  input  wire logic             mem_uc,
  input  wire logic [PA_W-1:0]  mem_addr,
  input  wire logic [ENT_W-1:0] mem_wdata,
  output logic                  mem_done,
  output logic      [127:0]     mem_rdata
);
  logic [ENT_W-1:0] qw [longint];
  logic [3:0]       wait_cnt;
  logic [PA_W-1:0]  last_addr;
  logic             last_uc;
  int               n_rd;
  logic [ENT_W-1:0] ent;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_done <= 1'b0;
      mem_rdata <= '0;
      wait_cnt <= '0;
      n_rd <= 0;
    end else begin
      mem_done <= 1'b0;
      // Stale line toggles every cycle, so a sample one cycle late sees the entry inverted
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_done) begin
        if (wait_cnt < lat) begin
          wait_cnt <= wait_cnt + 4'h1;
        end else begin
          wait_cnt <= '0;
          mem_done <= 1'b1;
          last_addr <= mem_addr;
          last_uc <= mem_uc;
          ent = qw.exists(longint'(mem_addr >> 3)) ? qw[longint'(mem_addr >> 3)] : 64'h0;
          if (mem_we) begin
            qw[longint'(mem_addr >> 3)] = mem_wdata;
          end else begin
            n_rd <= n_rd + 1;
            // Other half inverted: the wrong slot pick gives a wrong entry
            mem_rdata <= mem_addr[3] ? {ent, ~ent} : {~ent, ent};
          end
        end
      end
    end
  end
endmodule : gptw_mem_model

// File: test/tb.sv
// Self-checking bench for the page walker: APB setup, table updates, walks.
// Assumes gptw_mem_model stands in for the memory holding the tables.
`timescale 1ns/100ps
module tb import gptw_pkg::*; ;
  localparam longint GB = 64'h10_0000;
  localparam longint PDB = 64'h20_0000;
  localparam logic [63:0] E5 = 64'hFFFF_C0AB_CDEF_1FFF;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, req_valid, req_global;
  logic req_write, req_ready, upd_valid, resp_valid, resp_fault, resp_null;
  logic resp_wr_deny, resp_guest, mem_req, mem_we, mem_uc, mem_done, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, req_addr, upd_page;
  logic [63:0] upd_entry, mem_wdata;
  logic [45:0] resp_pa, mem_addr;
  logic [2:0] resp_mem_type;
  logic [127:0] mem_rdata;
  logic [3:0] lat;
  int err_count, n_compared, cyc, n0;
  gptw_walker DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .req_valid, .req_global, .req_write, .req_addr, .req_ready,
    .upd_valid, .upd_page, .upd_entry, .resp_valid, .resp_pa, .resp_fault, .resp_null,
    .resp_wr_deny, .resp_mem_type, .resp_guest, .mem_req, .mem_we, .mem_uc, .mem_addr,
    .mem_wdata, .mem_done, .mem_rdata);
  gptw_mem_model MEM (.pclk, .presetn, .lat, .mem_req, .mem_we, .mem_uc, .mem_addr,
    .mem_wdata, .mem_done, .mem_rdata);
  always #4 pclk = ~pclk;
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  always @(posedge pclk) begin
    cyc++;
    // Whole run needs under two hundred cycles
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic put(input longint a, input logic [63:0] v);
    MEM.qw[a >> 3] = v;
  endtask : put
  // Raise one request, hold it until taken, then wait for its answer
  task automatic xl(input logic g, input logic w, input logic [31:0] va);
    n0 = MEM.n_rd;
    @(posedge pclk);
    req_valid <= 1'b1;
    req_global <= g;
    req_write <= w;
    req_addr <= va;
    do @(posedge pclk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    do @(posedge pclk); while (resp_valid !== 1'b1);
  endtask : xl
  initial begin
    {pclk, presetn, psel, penable, pwrite, req_valid, req_global, req_write} = '0;
    {upd_valid, paddr, pwdata, req_addr, upd_page, upd_entry, lat} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFF_CTRL, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    check(e, 1'b1);
    apb(1'b1, OFF_GBASE_L, GB[31:0]);
    apb(1'b1, OFF_PDP_L, PDB[31:0]);
    apb(1'b0, OFF_GBASE_L, 32'h0);
    check(rd, GB[31:0]);
    @(posedge pclk);
    upd_valid <= 1'b1;
    upd_page <= 32'h0000_5000;
    upd_entry <= E5;
    do @(posedge pclk); while (req_ready !== 1'b1);
    upd_valid <= 1'b0;
    do @(posedge pclk); while (req_ready !== 1'b1);
    check(MEM.qw[(GB + 40) >> 3], E5);
    check(MEM.last_uc, 1'b1);
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, OFF_CTRL, s);
      lat <= s ? 4'h4 : 4'h0;
      xl(1'b1, 1'b0, 32'h0000_5ABC);
      check(resp_pa[45:12], s ? E5[45:12] : {7'h0, E5[38:12]});
      check({resp_fault, MEM.last_addr, MEM.last_uc}, {1'b0, GB[45:0] + 46'd40, 1'b1});
    end
    put(GB + 32, 64'hFFFF_FFFF_FFFF_FFFE);
    xl(1'b1, 1'b0, 32'h0000_4000);
    check(resp_fault, 1'b1);
    apb(1'b1, OFF_CTRL, 32'h2);
    put(PDB + 16, 64'h30_07FD);
    put(64'h30_01B8, 64'hFFF0_0000_1234_509B);
    xl(1'b0, 1'b1, 32'h0043_7000);
    check(MEM.n_rd - n0, 2);
    check({resp_pa[45:12], resp_wr_deny, resp_mem_type}, {34'h12345, 1'b0, 3'h7});
    check(resp_guest, 1'b1);
    put(64'h30_01B8, 64'hFFF0_0000_1234_5099);
    xl(1'b0, 1'b1, 32'h0043_7000);
    check(MEM.n_rd - n0, 1);
    check(resp_wr_deny, 1'b1);
    apb(1'b1, OFF_CTRL, 32'h6);
    xl(1'b0, 1'b0, 32'h0043_7000);
    check(MEM.n_rd - n0, 2);
    put(PDB + 32, 64'h40_0801);
    put(64'h40_0280, 64'h56_7800_FC01);
    xl(1'b0, 1'b0, 32'h0085_7000);
    check(MEM.last_addr, 46'h40_0280);
    check(resp_pa[45:16], 30'h56_7800);
    put(64'h30_01C0, 64'h9999_9201);
    xl(1'b0, 1'b0, 32'h0043_8000);
    check({resp_null, resp_pa}, {1'b1, 46'h0});
    put(PDB + 48, 64'h30_0000);
    xl(1'b0, 1'b0, 32'h00C0_0000);
    check({resp_fault, MEM.n_rd - n0}, {1'b1, 32'h1});
    xl(1'b1, 1'b0, 32'h0000_5000);
    check({resp_guest, MEM.last_addr, MEM.last_uc}, {1'b0, GB[45:0] + 46'd40, 1'b1});
    report_and_stop();
  end
endmodule : tb
